// File: atc_pkg.sv
// Package of register map, field layout and reset values for the asynchronous 8-bit timer.
package atc_pkg;
  // ****************************************************************
  // Register byte offsets on the bus.
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL_A = 8'h60;
  localparam logic [7:0] OFS_CTRL_B = 8'h64;
  localparam logic [7:0] OFS_COUNT  = 8'h68;
  localparam logic [7:0] OFS_CMP_A  = 8'h6C;
  localparam logic [7:0] OFS_MASK   = 8'h70;
  localparam logic [7:0] OFS_CMP_B  = 8'h74;
  localparam logic [7:0] OFS_STATUS = 8'h78;
  localparam logic [7:0] OFS_FLAGS  = 8'h7C;

  // ****************************************************************
  // Field positions and write masks.
  // ****************************************************************
  localparam int         CB_FORCE_A   = 7;
  localparam int         CB_FORCE_B   = 6;
  localparam int         CB_WAVE_HI   = 3;
  localparam logic [7:0] CTRL_A_WMASK = 8'hF3;
  localparam logic [7:0] CTRL_B_WMASK = 8'h0F;
  localparam int         ST_EXT_CLK   = 6;
  localparam int         ST_ASYNC     = 5;
  localparam int         BUSY_COUNT   = 4;
  localparam int         BUSY_CMP_A   = 3;
  localparam int         BUSY_CMP_B   = 2;
  localparam int         BUSY_CTRL_A  = 1;
  localparam int         BUSY_CTRL_B  = 0;
  localparam int         IRQ_CMP_B    = 2;
  localparam int         IRQ_CMP_A    = 1;
  localparam int         IRQ_OVF      = 0;

  // ****************************************************************
  // Counter limits, reset values and prescaler tap masks.
  // ****************************************************************
  localparam logic [7:0] CNT_BOTTOM   = 8'h00;
  localparam logic [7:0] CNT_MAX      = 8'hFF;
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [2:0] MASK_RESET   = 3'h0;
  localparam logic [9:0] PRE_DIV8     = 10'h007;
  localparam logic [9:0] PRE_DIV32    = 10'h01F;
  localparam logic [9:0] PRE_DIV64    = 10'h03F;
  localparam logic [9:0] PRE_DIV128   = 10'h07F;
  localparam logic [9:0] PRE_DIV256   = 10'h0FF;
  localparam logic [9:0] PRE_DIV1024  = 10'h3FF;
  localparam logic [2:0] HSIZE_WORD   = 3'h2;

  // Bus slave phase.
  typedef enum logic {
    ATC_BUS_IDLE = 1'b0,
    ATC_BUS_DATA = 1'b1
  } atc_bus_e;
endpackage

// File: atc_timer.sv
// Asynchronous 8-bit timer with compare channels and an AHB-Lite register slave.
// Overview of operation
// - Force strobes act only in non-PWM modes; software keeps them zero in PWM.
// - A force strobe applies a compare action to its output using its output mode.
// - A forced compare sets no flag and never clears the counter.
// - Force bits and control B bits 5:4 always read as zero.
// - Clock select: stop, undivided, then divide by 8,32,64,128,256,1024.
// - The count register is directly readable and writable.
// - A count write suppresses compare match on the next timer clock edge.
// - Both compare registers are compared continuously; matches set flags and drive outputs.
// - External clock enable with async mode enables pin buffer; crystal runs only when clear.
// - Async select picks the core clock or the oscillator pin as timer source.
// - Async writes set busy bits 4..0; hardware clears them when loaded.
// - Count reads are live; compare and control reads return temporary storage.
// - Mask holds three enables in bits 2:0; bits 7:3 read zero; resets zero.
// - Interrupt raised when enable, global enable and matching flag are set.
//
// Decided for this implementation: the AHB-Lite interface to the registers.
module atc_timer #(
  parameter int ADDR_W = 8
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  input  wire logic              i_hsel,
  input  wire logic [ADDR_W-1:0] i_haddr,
  input  wire logic [1:0]        i_htrans,
  input  wire logic              i_hwrite,
  input  wire logic [2:0]        i_hsize,
  input  wire logic [31:0]       i_hwdata,
  input  wire logic              i_hready,
  output logic                   o_hreadyout,
  output logic [31:0]            o_hrdata,
  output logic                   o_hresp,
  input  wire logic              i_timer_osc_in_pin,
  input  wire logic              i_global_irq_en,
  output logic                   o_wave_out_a,
  output logic                   o_wave_out_b,
  output logic                   o_irq_overflow,
  output logic                   o_irq_compare_a,
  output logic                   o_irq_compare_b,
  output logic                   o_ext_clock_buf_en,
  output logic                   o_crystal_osc_en
);
  // ****************************************************************
  // State of the block.
  // ****************************************************************
  typedef struct packed {
    atc_pkg::atc_bus_e bus;
    logic [7:0]        addr;
    logic              wr;
    logic              hready;
    logic [31:0]       hrdata;
    logic              pin_s1;
    logic              pin_s2;
    logic              pin_s3;
    logic [9:0]        pre;
    logic [7:0]        cnt;
    logic              down;
    logic              block;
    logic [7:0]        ctrl_a;
    logic [7:0]        ctrl_b;
    logic [7:0]        cmp_a;
    logic [7:0]        cmp_b;
    logic [7:0]        t_ctrl_a;
    logic [7:0]        t_ctrl_b;
    logic [7:0]        t_cnt;
    logic [7:0]        t_cmp_a;
    logic [7:0]        t_cmp_b;
    logic [1:0]        t_force;
    logic [4:0]        busy;
    logic              ext_en;
    logic              as_sel;
    logic [2:0]        mask;
    logic [2:0]        flags;
    logic [2:0]        irq;
    logic              wave_a;
    logic              wave_b;
    logic              osc_en;
    logic              buf_en;
  } atc_state_s;

  atc_state_s st_q;
  atc_state_s st_d;
  logic       src_tick;
  logic       t_tick;
  logic [9:0] tap;
  logic [2:0] wgm;
  logic       pwm;
  logic [7:0] top;
  logic       match_a;
  logic       match_b;
  logic       at_top;
  logic       bottom;
  logic       ovf;
  logic       wr_hit;
  logic [7:0] wdat;
  logic [1:0] force_now;

  // Prescaler tap for a clock select code; zero means every source tick.
  function automatic logic [9:0] div_tap(input logic [2:0] cs);
    case (cs)
      3'h2:    div_tap = atc_pkg::PRE_DIV8;
      3'h3:    div_tap = atc_pkg::PRE_DIV32;
      3'h4:    div_tap = atc_pkg::PRE_DIV64;
      3'h5:    div_tap = atc_pkg::PRE_DIV128;
      3'h6:    div_tap = atc_pkg::PRE_DIV256;
      3'h7:    div_tap = atc_pkg::PRE_DIV1024;
      default: div_tap = 10'h000;
    endcase
  endfunction

  // Non-PWM compare action: toggle, clear or set; mode zero leaves the level alone.
  function automatic logic cmp_act(input logic old, input logic [1:0] com);
    case (com)
      2'h1:    cmp_act = ~old;
      2'h2:    cmp_act = 1'b0;
      2'h3:    cmp_act = 1'b1;
      default: cmp_act = old;
    endcase
  endfunction

  // Next waveform level for one channel on a timer tick.
  function automatic logic wave_step(input logic old, input logic [1:0] com,
                                     input logic pw, input logic fast,
                                     input logic dn, input logic mt, input logic bt);
    wave_step = old;
    if (!pw) begin
      if (mt) begin
        wave_step = cmp_act(old, com);
      end
    end else if (com[1]) begin
      if (mt) begin
        wave_step = com[0] ^ (dn & ~fast);
      end else if (bt && fast) begin
        wave_step = ~com[0];
      end
    end
  endfunction

  // ****************************************************************
  // Timer source and tick decode.
  // ****************************************************************
  // The pin edge is taken from the second and third stages only.
  assign src_tick  = st_q.as_sel ? (st_q.pin_s2 & ~st_q.pin_s3) : 1'b1;
  assign tap       = div_tap(st_q.ctrl_b[2:0]);
  assign t_tick    = src_tick && (st_q.ctrl_b[2:0] != 3'h0)
                     && ((st_q.pre & tap) == tap);
  assign wgm       = {st_q.ctrl_b[atc_pkg::CB_WAVE_HI], st_q.ctrl_a[1:0]};
  assign pwm       = wgm[0];
  assign top       = (wgm[2] || wgm == 3'h2) ? st_q.cmp_a : atc_pkg::CNT_MAX;
  assign at_top    = st_q.cnt == top;
  // A fresh count write blocks matches for exactly one timer tick.
  assign match_a   = t_tick && !st_q.block && st_q.cnt == st_q.cmp_a;
  assign match_b   = t_tick && !st_q.block && st_q.cnt == st_q.cmp_b;
  assign bottom    = pwm && wgm[1] && at_top;
  assign ovf       = t_tick && (wgm[1:0] == 2'h1
                     ? (st_q.down && st_q.cnt == atc_pkg::CNT_BOTTOM)
                     : (pwm ? at_top : st_q.cnt == atc_pkg::CNT_MAX));
  assign wr_hit    = st_q.bus == atc_pkg::ATC_BUS_DATA && st_q.wr;
  assign wdat      = i_hwdata[7:0];
  assign force_now = (wr_hit && !st_q.as_sel && st_q.addr == atc_pkg::OFS_CTRL_B)
                     ? wdat[atc_pkg::CB_FORCE_A -: 2]
                     : ((src_tick && st_q.busy[atc_pkg::BUSY_CTRL_B]) ? st_q.t_force : 2'h0);

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  // Order: counting, then async loads, then bus writes, so a write in the
  // same cycle as a load leaves its busy bit set and is loaded next tick.
  always_comb begin
    st_d        = st_q;
    st_d.pin_s1 = i_timer_osc_in_pin;
    st_d.pin_s2 = st_q.pin_s1;
    st_d.pin_s3 = st_q.pin_s2;
    st_d.hready = 1'b1;
    if (src_tick) begin
      st_d.pre = (st_d.pre == atc_pkg::PRE_DIV1024) ? 10'h000 : st_q.pre + 10'h001;
    end
    // Counting; the lower limit is zero in every mode.
    if (t_tick) begin
      st_d.block = 1'b0;
      if (wgm[1:0] == 2'h1) begin
        if (!st_q.down && at_top) begin
          st_d.down = 1'b1;
          st_d.cnt  = st_q.cnt - 8'h01;
        end else if (st_q.down && st_q.cnt == atc_pkg::CNT_BOTTOM) begin
          st_d.down = 1'b0;
          st_d.cnt  = st_q.cnt + 8'h01;
        end else begin
          st_d.cnt  = st_q.down ? st_q.cnt - 8'h01 : st_q.cnt + 8'h01;
        end
      end else if ((wgm == 3'h2 && match_a) || (wgm[1:0] == 2'h3 && at_top)) begin
        st_d.cnt  = atc_pkg::CNT_BOTTOM;
        st_d.down = 1'b0;
      end else begin
        st_d.cnt  = st_q.cnt + 8'h01;
        st_d.down = 1'b0;
      end
      st_d.wave_a = wave_step(st_q.wave_a, st_q.ctrl_a[7:6], pwm, wgm[1], st_q.down,
                              match_a, bottom);
      st_d.wave_b = wave_step(st_q.wave_b, st_q.ctrl_a[5:4], pwm, wgm[1], st_q.down,
                              match_b, bottom);
    end
    // Forced compares touch only the outputs, never flags or the count.
    if (!pwm && force_now[1]) begin
      st_d.wave_a = cmp_act(st_d.wave_a, st_q.ctrl_a[7:6]);
    end
    if (!pwm && force_now[0]) begin
      st_d.wave_b = cmp_act(st_d.wave_b, st_q.ctrl_a[5:4]);
    end
    // Async loads from temporary storage on the synchronised pin edge.
    if (st_q.as_sel && src_tick) begin
      if (st_q.busy[atc_pkg::BUSY_COUNT]) begin
        st_d.cnt   = st_q.t_cnt;
        st_d.block = 1'b1;
      end
      if (st_q.busy[atc_pkg::BUSY_CMP_A]) st_d.cmp_a = st_q.t_cmp_a;
      if (st_q.busy[atc_pkg::BUSY_CMP_B]) st_d.cmp_b = st_q.t_cmp_b;
      if (st_q.busy[atc_pkg::BUSY_CTRL_A]) st_d.ctrl_a = st_q.t_ctrl_a;
      if (st_q.busy[atc_pkg::BUSY_CTRL_B]) st_d.ctrl_b = st_q.t_ctrl_b;
      st_d.busy = 5'h00;
    end
    // Hardware set wins over a same-cycle one-to-clear.
    if (wr_hit && st_q.addr == atc_pkg::OFS_FLAGS) begin
      st_d.flags = st_q.flags & ~wdat[2:0];
    end
    st_d.flags = st_d.flags | {match_b, match_a, ovf};
    st_d.irq   = st_q.flags & st_q.mask & {3{i_global_irq_en}};
    // Bus writes in the data phase.
    if (wr_hit) begin
      if (st_q.addr == atc_pkg::OFS_COUNT) begin
        st_d.t_cnt = wdat;
        if (st_q.as_sel) begin
          st_d.busy[atc_pkg::BUSY_COUNT] = 1'b1;
        end else begin
          st_d.cnt   = wdat;
          st_d.block = 1'b1;
        end
      end else if (st_q.addr == atc_pkg::OFS_CMP_A) begin
        st_d.t_cmp_a = wdat;
        if (st_q.as_sel) st_d.busy[atc_pkg::BUSY_CMP_A] = 1'b1;
        else st_d.cmp_a = wdat;
      end else if (st_q.addr == atc_pkg::OFS_CMP_B) begin
        st_d.t_cmp_b = wdat;
        if (st_q.as_sel) st_d.busy[atc_pkg::BUSY_CMP_B] = 1'b1;
        else st_d.cmp_b = wdat;
      end else if (st_q.addr == atc_pkg::OFS_CTRL_A) begin
        st_d.t_ctrl_a = wdat & atc_pkg::CTRL_A_WMASK;
        if (st_q.as_sel) st_d.busy[atc_pkg::BUSY_CTRL_A] = 1'b1;
        else st_d.ctrl_a = wdat & atc_pkg::CTRL_A_WMASK;
      end else if (st_q.addr == atc_pkg::OFS_CTRL_B) begin
        st_d.t_ctrl_b = wdat & atc_pkg::CTRL_B_WMASK;
        st_d.t_force  = wdat[atc_pkg::CB_FORCE_A -: 2];
        if (st_q.as_sel) st_d.busy[atc_pkg::BUSY_CTRL_B] = 1'b1;
        else st_d.ctrl_b = wdat & atc_pkg::CTRL_B_WMASK;
      end else if (st_q.addr == atc_pkg::OFS_MASK) begin
        st_d.mask = wdat[2:0];
      end else if (st_q.addr == atc_pkg::OFS_STATUS) begin
        st_d.ext_en = wdat[atc_pkg::ST_EXT_CLK];
        st_d.as_sel = wdat[atc_pkg::ST_ASYNC];
      end
    end
    // Pin buffer and crystal follow the status bits.
    st_d.buf_en = st_d.ext_en & st_d.as_sel;
    st_d.osc_en = ~st_d.ext_en & st_d.as_sel;
    // Address phase: every transfer gets one wait state, so writes land
    // before the next read is answered.
    if (st_q.bus == atc_pkg::ATC_BUS_DATA) begin
      st_d.bus    = atc_pkg::ATC_BUS_IDLE;
      st_d.hrdata = 32'h0000_0000;
      if (!st_q.wr) begin
        if (st_q.addr == atc_pkg::OFS_COUNT) begin
          st_d.hrdata[7:0] = st_q.cnt;
        end else if (st_q.addr == atc_pkg::OFS_CMP_A) begin
          st_d.hrdata[7:0] = st_q.t_cmp_a;
        end else if (st_q.addr == atc_pkg::OFS_CMP_B) begin
          st_d.hrdata[7:0] = st_q.t_cmp_b;
        end else if (st_q.addr == atc_pkg::OFS_CTRL_A) begin
          st_d.hrdata[7:0] = st_q.t_ctrl_a;
        end else if (st_q.addr == atc_pkg::OFS_CTRL_B) begin
          st_d.hrdata[7:0] = st_q.t_ctrl_b;
        end else if (st_q.addr == atc_pkg::OFS_MASK) begin
          st_d.hrdata[7:0] = {5'h00, st_q.mask};
        end else if (st_q.addr == atc_pkg::OFS_STATUS) begin
          st_d.hrdata[7:0] = {1'b0, st_q.ext_en, st_q.as_sel, st_q.busy};
        end else if (st_q.addr == atc_pkg::OFS_FLAGS) begin
          st_d.hrdata[7:0] = {5'h00, st_q.flags};
        end
      end
    end else if (i_hsel && i_hready && i_htrans[1]) begin
      st_d.bus    = atc_pkg::ATC_BUS_DATA;
      st_d.hready = 1'b0;
      st_d.addr   = i_haddr[7:0];
      st_d.wr     = i_hwrite && (i_hsize == atc_pkg::HSIZE_WORD);
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  // Reset clears every register except hready, which resets to one; the mask reset is explicit.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q        <= '0;
      st_q.bus    <= atc_pkg::ATC_BUS_IDLE;
      st_q.hready <= 1'b1;
      st_q.mask   <= atc_pkg::MASK_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register; response is always OKAY.
  assign o_hreadyout        = st_q.hready;
  assign o_hrdata           = st_q.hrdata;
  assign o_hresp            = 1'b0;
  assign o_wave_out_a       = st_q.wave_a;
  assign o_wave_out_b       = st_q.wave_b;
  assign o_irq_overflow     = st_q.irq[atc_pkg::IRQ_OVF];
  assign o_irq_compare_a    = st_q.irq[atc_pkg::IRQ_CMP_A];
  assign o_irq_compare_b    = st_q.irq[atc_pkg::IRQ_CMP_B];
  assign o_ext_clock_buf_en = st_q.buf_en;
  assign o_crystal_osc_en   = st_q.osc_en;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  sequence s_async_write(logic [7:0] a);
    wr_hit && st_q.as_sel && st_q.addr == a;
  endsequence

  chk_ctrl_b_read_zero: assert property (
    st_q.bus == atc_pkg::ATC_BUS_DATA && !st_q.wr && st_q.addr == atc_pkg::OFS_CTRL_B
    |=> o_hrdata[7:4] == 4'h0 && o_hreadyout)
    else $error("control B upper bits read nonzero");
  chk_mask_upper_zero: assert property (
    st_q.bus == atc_pkg::ATC_BUS_DATA && !st_q.wr && st_q.addr == atc_pkg::OFS_MASK
    |=> o_hrdata[7:3] == 5'h00)
    else $error("mask upper bits read nonzero");
  chk_force_no_flag: assert property (
    force_now != 2'h0 && !t_tick && !st_q.busy[atc_pkg::BUSY_COUNT] &&
    !(wr_hit && st_q.addr != atc_pkg::OFS_CTRL_B) |=> $stable(st_q.flags) && $stable(st_q.cnt))
    else $error("forced compare changed a flag or the counter");
  chk_busy_count_set: assert property (
    s_async_write(atc_pkg::OFS_COUNT) |=> st_q.busy[atc_pkg::BUSY_COUNT])
    else $error("count busy not set by async write");
  chk_busy_clears_load: assert property (
    st_q.busy[atc_pkg::BUSY_CMP_A] && src_tick && st_q.as_sel && !wr_hit
    |=> !st_q.busy[atc_pkg::BUSY_CMP_A] && st_q.cmp_a == $past(st_q.t_cmp_a))
    else $error("compare A busy not cleared on load");
  chk_stop_holds: assert property (
    st_q.ctrl_b[2:0] == 3'h0 && !wr_hit && st_q.busy == 5'h00 |=> $stable(st_q.cnt))
    else $error("stopped counter moved");
  chk_block_match: assert property (
    st_q.block && t_tick && !wr_hit |=> $stable(st_q.flags[atc_pkg::IRQ_CMP_B:atc_pkg::IRQ_CMP_A]))
    else $error("compare match not suppressed after count write");
  chk_irq_gate: assert property (
    st_q.flags[atc_pkg::IRQ_OVF] && st_q.mask[atc_pkg::IRQ_OVF] && i_global_irq_en
    |=> o_irq_overflow)
    else $error("overflow interrupt not raised");
endmodule

// File: async_timer8_control_test.sv
// Self-checking testbench of the asynchronous 8-bit timer block.
module async_timer8_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, hsel, hwrite, hreadyout, hresp, pin, gie;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, seed, rd;
  logic        wa, wb, iov, ica, icb, extb, xosc;
  int          n_errors, compares;
  atc_timer i_dut (.i_core_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hrdata(hrdata), .o_hresp(hresp),
    .i_timer_osc_in_pin(pin), .i_global_irq_en(gie), .o_wave_out_a(wa),
    .o_wave_out_b(wb), .o_irq_overflow(iov), .o_irq_compare_a(ica),
    .o_irq_compare_b(icb), .o_ext_clock_buf_en(extb), .o_crystal_osc_en(xosc));
  // ****
  // Helpers
  // ****
  // Galois-free shift register: repeatable stimulus from a fixed seed.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Divisor that a clock select code should give.
  function automatic int div(input int cs);
    int t[8] = '{1, 1, 8, 32, 64, 128, 256, 1024};
    return t[cs];
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One single AHB-Lite transfer; waits on the slave's answer, never on a count.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdat);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= atc_pkg::HSIZE_WORD;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rdat = hrdata;
    check("hresp_okay", {31'h0, hresp}, 32'h0000_0000);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    bus(1'b0, a, 32'h0000_0000, v);
    check(nm, v, e);
  endtask
  // Two slow pin edges, enough for the synchroniser to load pending writes.
  task automatic pin_pulses();
    repeat (2) begin
      pin <= 1'b1;
      repeat (8) @(posedge clk);
      pin <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ****
  // Clock, reset and watchdog
  // ****
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // The run needs about 13000 cycles; the limit leaves generous room.
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
  // ****
  // Main sequence
  // ****
  initial begin
    rst = 1'b1; hsel = 1'b0; haddr = 8'h00; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0000_0000; pin = 1'b0; gie = 1'b1;
    n_errors = 0; compares = 0; seed = 32'hbd68_b696;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Mask resets to zero and keeps only its three enables.
    rd_chk("mask_reset", atc_pkg::OFS_MASK, 32'h0000_0000);
    wr(atc_pkg::OFS_MASK, 32'hFFFF_FFFF);
    rd_chk("mask_bits", atc_pkg::OFS_MASK, 32'h0000_0007);
    rd_chk("unmapped", 8'h40, 32'h0000_0000);
    // Force and reserved bits read zero; counter stays stopped.
    wr(atc_pkg::OFS_CTRL_B, 32'h0000_00F8);
    rd_chk("ctrl_b_read", atc_pkg::OFS_CTRL_B, 32'h0000_0008);
    // Random count and compare values read back as written while stopped.
    repeat (4) begin
      seed = lfsr(seed);
      wr(atc_pkg::OFS_COUNT, {24'h0, seed[7:0]});
      wr(atc_pkg::OFS_CMP_B, {24'h0, seed[15:8]});
      rd_chk("count_rw", atc_pkg::OFS_COUNT, {24'h0, seed[7:0]});
      rd_chk("cmp_b_rw", atc_pkg::OFS_CMP_B, {24'h0, seed[15:8]});
    end
    // Forced compares in clear-on-match mode: toggle output A, set output B, no flag, no clear.
    wr(atc_pkg::OFS_CTRL_A, 32'h0000_0072);
    wr(atc_pkg::OFS_CTRL_B, 32'h0000_0000);
    wr(atc_pkg::OFS_CMP_A, 32'h0000_0010);
    wr(atc_pkg::OFS_COUNT, 32'h0000_0050);
    for (int k = 0; k < 3; k++) begin
      wr(atc_pkg::OFS_CTRL_B, 32'h0000_00C0);
      repeat (2) @(posedge clk);
      check("force_a_out", {31'h0, wa}, {31'h0, (k % 2 == 0)});
      check("force_b_out", {31'h0, wb}, 32'h0000_0001);
      check("force_no_irq", {29'h0, icb, ica, iov}, 32'h0000_0000);
    end
    rd_chk("force_no_flag", atc_pkg::OFS_FLAGS, 32'h0000_0000);
    rd_chk("force_no_clear", atc_pkg::OFS_COUNT, 32'h0000_0050);
    // Compare matches and overflow raise flags and gated requests.
    wr(atc_pkg::OFS_CTRL_A, 32'h0000_0000);
    wr(atc_pkg::OFS_CMP_A, 32'h0000_0000);
    wr(atc_pkg::OFS_CMP_B, 32'h0000_00F8);
    wr(atc_pkg::OFS_COUNT, 32'h0000_00F0);
    wr(atc_pkg::OFS_CTRL_B, 32'h0000_0001);
    repeat (40) @(posedge clk);
    wr(atc_pkg::OFS_CTRL_B, 32'h0000_0000);
    rd_chk("match_flags", atc_pkg::OFS_FLAGS, 32'h0000_0007);
    check("irq_on", {29'h0, icb, ica, iov}, 32'h0000_0007);
    gie <= 1'b0;
    repeat (3) @(posedge clk);
    check("irq_gated", {29'h0, icb, ica, iov}, 32'h0000_0000);
    gie <= 1'b1;
    wr(atc_pkg::OFS_MASK, 32'h0000_0002);
    repeat (3) @(posedge clk);
    check("irq_masked", {29'h0, icb, ica, iov}, 32'h0000_0002);
    wr(atc_pkg::OFS_FLAGS, 32'h0000_0007);
    rd_chk("flags_clear", atc_pkg::OFS_FLAGS, 32'h0000_0000);
    // A reset in mid-run clears the outputs and the mask once more.
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("reset_outputs", {27'h0, wa, wb, icb, ica, iov}, 32'h0000_0000);
    rd_chk("mask_rerun", atc_pkg::OFS_MASK, 32'h0000_0000);
    // Every clock select code: count after eight divided periods.
    for (int cs = 0; cs < 8; cs++) begin
      wr(atc_pkg::OFS_CTRL_B, 32'h0000_0000);
      wr(atc_pkg::OFS_COUNT, 32'h0000_0000);
      wr(atc_pkg::OFS_CTRL_B, cs);
      repeat (8 * div(cs)) @(posedge clk);
      bus(1'b0, atc_pkg::OFS_COUNT, 32'h0000_0000, rd);
      if (cs == 0) begin
        check("count_stopped", rd, 32'h0000_0000);
      end else begin
        check("count_rate", 32'(rd >= 7 && rd <= ((cs == 1) ? 13 : 9)), 32'h1);
      end
    end
    wr(atc_pkg::OFS_CTRL_B, 32'h0000_0000);
    // Clear-on-match mode wraps the count at compare A; normal mode would run past it.
    wr(atc_pkg::OFS_CTRL_A, 32'h0000_0042);
    wr(atc_pkg::OFS_CMP_A, 32'h0000_0005);
    wr(atc_pkg::OFS_COUNT, 32'h0000_0000);
    wr(atc_pkg::OFS_CTRL_B, 32'h0000_0001);
    repeat (40) @(posedge clk);
    bus(1'b0, atc_pkg::OFS_COUNT, 32'h0000_0000, rd);
    check("ctc_wrap", 32'(rd <= 5), 32'h1);
    wr(atc_pkg::OFS_CTRL_B, 32'h0000_0000);
    // Asynchronous mode: external input buffer, then busy flags per register.
    wr(atc_pkg::OFS_STATUS, 32'h0000_0040);
    wr(atc_pkg::OFS_STATUS, 32'h0000_0060);
    repeat (2) @(posedge clk);
    check("ext_buf", {30'h0, extb, xosc}, 32'h0000_0002);
    begin
      logic [7:0] ofs[5];
      ofs = '{atc_pkg::OFS_COUNT, atc_pkg::OFS_CMP_A, atc_pkg::OFS_CMP_B,
              atc_pkg::OFS_CTRL_A, atc_pkg::OFS_CTRL_B};
      for (int i = 0; i < 5; i++) begin
        seed = lfsr(seed);
        wr(ofs[i], (i == 4) ? 32'h0000_0008 : {24'h0, seed[7:0] & ((i == 3) ? 8'hF2 : 8'hFF)});
        rd_chk("busy_set", atc_pkg::OFS_STATUS, 32'h0000_0060 | (32'h1 << (4 - i)));
        if (i == 1) begin
          rd_chk("temp_read", ofs[i], {24'h0, seed[7:0]});
        end
        pin_pulses();
        rd_chk("busy_clear", atc_pkg::OFS_STATUS, 32'h0000_0060);
      end
    end
    wr(atc_pkg::OFS_STATUS, 32'h0000_0020);
    repeat (2) @(posedge clk);
    check("crystal_on", {30'h0, extb, xosc}, 32'h0000_0001);
    wr(atc_pkg::OFS_STATUS, 32'h0000_0000);
    repeat (2) @(posedge clk);
    check("sync_mode", {30'h0, extb, xosc}, 32'h0000_0000);
    report_and_stop();
  end
endmodule
